// ===== tcv_timer.sv
// Function
// - Up mode: outputs act on match, wrap.
// - Continuous mode: outputs act on match, channel0 match.
// - Up/down: outputs act on match, period.
// - Two interrupt requests: channel0, shared.
// - Capture sets channel flag.
// - Compare match sets channel flag.
// - Software writes channel flags directly.
// - Request needs channel enable and global enable.
// - Channel0 highest, cleared on service acknowledge.
// - Channels 1, 2, overflow share request.
// - Vector shows highest enabled pending source.
// - Vector access clears reported flag.
// - Remaining flag requests again at once.
// - Channel 1 beats channel 2.
// - Vectors 0,2,4,10; 6 and 8 reserved.
// - Mode 0 output immediate, others clocked.
// - Up/down overflow on 1 to 0.
//
// Holds the three-channel 16-bit timer with its output units and interrupt vectors.
// Assumes capture inputs are synchronous to clk_i and the core pulses the service ack.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "tcv_params.svh"

module tcv_timer
    import tcv_pkg::*;
#(
    parameter int NCH = 3                       // Number of capture/compare channels.
)(
    input  wire logic        clk_i,             // Timer clock, 100 MHz.
    input  wire logic        resetn_i,          // Asynchronous reset, active low.
    input  wire logic [15:0] addr_i,            // Register byte offset.
    input  wire logic [15:0] wdata_i,           // Write data.
    input  wire logic        wr_i,              // Write strobe.
    input  wire logic        rd_i,              // Read strobe.
    output logic      [15:0] rdata_o,           // Read data, one cycle after read.
    input  wire logic        global_irq_enable_i, // Core global interrupt enable.
    input  wire logic        ch0_irq_ack_i,     // Core services channel 0 request.
    input  wire logic [2:0]  capture_i,         // Capture event pulses per channel.
    output logic             ch0_irq_o,         // Dedicated channel 0 request.
    output logic             shared_irq_o,      // Shared vector request.
    output logic [2:0]       channel_output_o   // Output unit signals.
);

    // -------------------------------------------------------------------------
    // Storage.
    // -------------------------------------------------------------------------
    logic [15:0] count_ff;                       // Counter.
    logic        down_ff;                        // Count direction, high while counting down.
    logic [1:0]  cmode_ff;                       // Counting mode.
    logic        ovf_ie_ff;                      // Overflow interrupt enable.
    logic        ovf_flag_ff;                    // Overflow flag.
    logic [15:0] chval_ff   [NCH];               // Channel values.
    logic [2:0]  omode_ff   [NCH];               // Output mode bits.
    logic        ch_ie_ff   [NCH];               // Channel interrupt enables.
    logic        ch_flag_ff [NCH];               // Channel interrupt flags.
    logic        out_bit_ff [NCH];               // Output control bits.
    logic        cap_ff     [NCH];               // Capture mode select.
    logic        unit_ff    [NCH];               // Clocked output unit state.
    logic [15:0] rdata_ff;                       // Registered read data.

    // -------------------------------------------------------------------------
    // Decode helpers.
    // -------------------------------------------------------------------------
    // Address match shared by the write and read paths.
    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction

    // Offset of a channel's control word.
    function automatic logic [15:0] ctl_ofs(input int ch);
        ctl_ofs = 16'(`TCV_OFS_CH0_CTRL + 2 * ch);
    endfunction

    // Offset of a channel's value word.
    function automatic logic [15:0] val_ofs(input int ch);
        val_ofs = 16'(`TCV_OFS_CH0_VALUE + 2 * ch);
    endfunction

    // -------------------------------------------------------------------------
    // Counter events.
    // -------------------------------------------------------------------------
    logic running;                               // Counter advances.
    logic wrap_up;                               // Up mode roll from period to zero.
    logic ovf_evt;                               // Overflow flag event.
    logic wr_count;                              // Software writes the counter.
    logic clr_req;                               // Clear bit written.
    logic [15:0] nxt_count;                      // Next counter value.
    logic        nxt_down;                       // Next direction.

    assign running  = (cmode_ff != 2'(TCV_STOP));
    assign wr_count = wr_i && hit(addr_i, `TCV_OFS_COUNT);
    assign clr_req  = wr_i && hit(addr_i, `TCV_OFS_TIMER_CTRL) && wdata_i[`TCV_TC_CLEAR];
    assign wrap_up  = running && (cmode_ff == 2'(TCV_UP)) && (count_ff >= chval_ff[0]);

    // Next count and direction for each counting mode.
    always_comb
    begin
        nxt_count = count_ff;
        nxt_down  = down_ff;
        ovf_evt   = 1'b0;
        case (cmode_ff)
            2'(TCV_UP):
            begin
                nxt_count = wrap_up ? 16'h0000 : 16'(count_ff + 16'h0001);
                ovf_evt   = wrap_up;
            end
            2'(TCV_CONT):
            begin
                nxt_count = 16'(count_ff + 16'h0001);
                ovf_evt   = (count_ff == 16'hffff);
            end
            2'(TCV_UPDN):
            begin
                if (down_ff)
                begin
                    nxt_count = (count_ff == 16'h0000) ? 16'h0001 : 16'(count_ff - 16'h0001);
                    nxt_down  = (count_ff > 16'h0001);
                    ovf_evt   = (count_ff == 16'h0001);
                end
                else
                begin
                    // Turn round at the period; a shrunk period starts descent at once.
                    if (count_ff >= chval_ff[0])
                    begin
                        nxt_count = (count_ff == 16'h0000) ? 16'h0000
                                    : 16'(count_ff - 16'h0001);
                        nxt_down  = (count_ff != 16'h0000);
                    end
                    else
                    begin
                        nxt_count = 16'(count_ff + 16'h0001);
                    end
                end
            end
            default:
            begin
                nxt_count = count_ff;
            end
        endcase
    end

    // Counter and direction; software write or clear overrides counting.
    // Trade-off: the counter steps on every clock with no divider, which keeps
    // match timing simple but limits the longest period to 65536 clocks, or 131070 clocks in up/down mode.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            count_ff <= `TCV_RST_WORD;
            down_ff  <= 1'b0;
        end
        else if (clr_req)
        begin
            count_ff <= `TCV_RST_WORD;
            down_ff  <= 1'b0;
        end
        else if (wr_count)
        begin
            count_ff <= wdata_i;
        end
        else
        begin
            count_ff <= nxt_count;
            down_ff  <= nxt_down;
        end
    end

    // -------------------------------------------------------------------------
    // Vector generation.
    // -------------------------------------------------------------------------
    logic        pend1;                          // Channel 1 enabled and pending.
    logic        pend2;                          // Channel 2 enabled and pending.
    logic        pendo;                          // Overflow enabled and pending.
    logic [15:0] vector;                         // Current vector number.
    logic        vec_access;                     // Any access to the vector register.

    assign pend1 = ch_flag_ff[1] && ch_ie_ff[1];
    assign pend2 = ch_flag_ff[2] && ch_ie_ff[2];
    assign pendo = ovf_flag_ff && ovf_ie_ff;
    // A write to the vector register stores nothing, but it still counts as an
    // access and clears the reported flag, exactly as a read does.
    assign vec_access = (wr_i || rd_i) && hit(addr_i, `TCV_OFS_IRQ_VECTOR);

    // Fixed priority: channel 1, channel 2, overflow.
    always_comb
    begin
        if (pend1)
            vector = `TCV_VEC_CH1;
        else if (pend2)
            vector = `TCV_VEC_CH2;
        else if (pendo)
            vector = `TCV_VEC_OVF;
        else
            vector = `TCV_VEC_NONE;
    end

    // Requests combine flag, enable and the core's global enable.
    assign ch0_irq_o    = ch_flag_ff[0] && ch_ie_ff[0] && global_irq_enable_i;
    // A still-pending source keeps the level high, so it asks again at once.
    assign shared_irq_o = (vector != `TCV_VEC_NONE) && global_irq_enable_i;

    // -------------------------------------------------------------------------
    // Timer control register.
    // -------------------------------------------------------------------------
    // Overflow flag: a hardware event wins over a clear in the same cycle.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cmode_ff    <= 2'h0;
            ovf_ie_ff   <= 1'b0;
            ovf_flag_ff <= 1'b0;
        end
        else
        begin
            if (wr_i && hit(addr_i, `TCV_OFS_TIMER_CTRL))
            begin
                cmode_ff  <= wdata_i[`TCV_TC_MODE_HI:`TCV_TC_MODE_LO];
                ovf_ie_ff <= wdata_i[`TCV_TC_OVF_IE];
            end
            if (ovf_evt)
                ovf_flag_ff <= 1'b1;
            else if (wr_i && hit(addr_i, `TCV_OFS_TIMER_CTRL))
                ovf_flag_ff <= wdata_i[`TCV_TC_OVF_FLAG];
            else if (vec_access && !pend1 && !pend2 && pendo)
                ovf_flag_ff <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Channels.
    // -------------------------------------------------------------------------
    logic [NCH-1:0] match;                       // Counter counts onto channel value.

    generate
        for (genvar g = 0; g < NCH; g++)
        begin : g_ch
            logic set_evt;                       // Hardware sets the flag.
            logic clr_vec;                       // Vector access clears this flag.
            logic wr_ctl;                        // Control word written.
            logic cyc_b;                         // Secondary event of the output unit.

            // A match is counted only on a real count step onto the value.
            assign match[g] = running && !wr_count && !clr_req && (nxt_count == chval_ff[g])
                              && (nxt_count != count_ff);
            assign wr_ctl   = wr_i && hit(addr_i, ctl_ofs(g));
            assign set_evt  = cap_ff[g] ? capture_i[g] : match[g];
            assign clr_vec  = vec_access && ((g == 1 && pend1)
                                          || (g == 2 && !pend1 && pend2));

            // Secondary event per counting mode.
            always_comb
            begin
                case (cmode_ff)
                    2'(TCV_UP):   cyc_b = wrap_up;
                    2'(TCV_CONT): cyc_b = match[0];
                    2'(TCV_UPDN): cyc_b = match[0];
                    default:      cyc_b = 1'b0;
                endcase
            end

            // Channel control fields and flag.
            // A hardware set wins over a software write or a service clear, so no event is lost.
            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    omode_ff[g]   <= 3'h0;
                    ch_ie_ff[g]   <= 1'b0;
                    out_bit_ff[g] <= 1'b0;
                    cap_ff[g]     <= 1'b0;
                    ch_flag_ff[g] <= 1'b0;
                end
                else
                begin
                    if (wr_ctl)
                    begin
                        omode_ff[g]   <= wdata_i[`TCV_CC_MODE_HI:`TCV_CC_MODE_LO];
                        ch_ie_ff[g]   <= wdata_i[`TCV_CC_IE];
                        out_bit_ff[g] <= wdata_i[`TCV_CC_OUT];
                        cap_ff[g]     <= wdata_i[`TCV_CC_CAP];
                    end
                    if (set_evt)
                        ch_flag_ff[g] <= 1'b1;
                    else if (wr_ctl)
                        ch_flag_ff[g] <= wdata_i[`TCV_CC_FLAG];
                    else if (g == 0 && ch0_irq_ack_i)
                        ch_flag_ff[g] <= 1'b0;
                    else if (clr_vec)
                        ch_flag_ff[g] <= 1'b0;
                end
            end

            // Channel value: software write, or capture of the counter.
            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    chval_ff[g] <= `TCV_RST_WORD;
                else if (wr_i && hit(addr_i, val_ofs(g)))
                    chval_ff[g] <= wdata_i;
                else if (cap_ff[g] && capture_i[g])
                    chval_ff[g] <= count_ff;
            end

            // Output unit; in up/down every match in either direction acts.
            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    unit_ff[g] <= 1'b0;
                else
                begin
                    case (omode_ff[g])
                        TCV_OM_OUTBIT: unit_ff[g] <= out_bit_ff[g];
                        TCV_OM_SET:    unit_ff[g] <= match[g] ? 1'b1 : unit_ff[g];
                        TCV_OM_TGLRST: unit_ff[g] <= match[g] ? ~unit_ff[g]
                                                    : (cyc_b ? 1'b0 : unit_ff[g]);
                        TCV_OM_SETRST: unit_ff[g] <= match[g] ? 1'b1
                                                    : (cyc_b ? 1'b0 : unit_ff[g]);
                        TCV_OM_TOGGLE: unit_ff[g] <= match[g] ? ~unit_ff[g] : unit_ff[g];
                        TCV_OM_RESET:  unit_ff[g] <= match[g] ? 1'b0 : unit_ff[g];
                        TCV_OM_TGLSET: unit_ff[g] <= match[g] ? ~unit_ff[g]
                                                    : (cyc_b ? 1'b1 : unit_ff[g]);
                        TCV_OM_RSTSET: unit_ff[g] <= match[g] ? 1'b0
                                                    : (cyc_b ? 1'b1 : unit_ff[g]);
                        default:       unit_ff[g] <= unit_ff[g];
                    endcase
                end
            end

            // Mode 0 bypasses the clocked unit so the bit shows at once.
            // Software must not pass through 000 when leaving another mode.
            assign channel_output_o[g] = (omode_ff[g] == 3'h0) ? out_bit_ff[g]
                                         : unit_ff[g];
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Read path.
    // -------------------------------------------------------------------------
    // Reads return one cycle later; unmapped offsets read zero.
    // Reading the vector has a side effect: the reported flag clears at the
    // same edge that captures the vector, so the value read names the source
    // that was just serviced.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rdata_ff <= `TCV_RST_WORD;
        else if (rd_i)
        begin
            rdata_ff <= `TCV_RST_WORD;
            if (hit(addr_i, `TCV_OFS_IRQ_VECTOR))
                rdata_ff <= vector;
            else if (hit(addr_i, `TCV_OFS_TIMER_CTRL))
                rdata_ff <= {10'h000, cmode_ff, 2'h0, ovf_ie_ff, ovf_flag_ff};
            else if (hit(addr_i, `TCV_OFS_COUNT))
                rdata_ff <= count_ff;
            for (int i = 0; i < NCH; i++)
            begin
                if (hit(addr_i, ctl_ofs(i)))
                    rdata_ff <= {7'h00, cap_ff[i], omode_ff[i], ch_ie_ff[i], 1'b0,
                                 channel_output_o[i], 1'b0, ch_flag_ff[i]};
                if (hit(addr_i, val_ofs(i)))
                    rdata_ff <= chval_ff[i];
            end
        end
    end

    assign rdata_o = rdata_ff;

endmodule // tcv_timer

// ===== tcv_params.svh
// Constants of the capture/compare timer: register offsets, field positions, reset values.
// Assumes a 16-bit register port addressed by byte offset.
`ifndef TCV_PARAMS_SVH
`define TCV_PARAMS_SVH

// -----------------------------------------------------------------------------
// Register offsets.
// -----------------------------------------------------------------------------
`define TCV_OFS_IRQ_VECTOR  16'h012e
`define TCV_OFS_TIMER_CTRL  16'h0160
`define TCV_OFS_CH0_CTRL    16'h0162
`define TCV_OFS_CH1_CTRL    16'h0164
`define TCV_OFS_CH2_CTRL    16'h0166
`define TCV_OFS_COUNT       16'h0170
`define TCV_OFS_CH0_VALUE   16'h0172
`define TCV_OFS_CH1_VALUE   16'h0174
`define TCV_OFS_CH2_VALUE   16'h0176

// -----------------------------------------------------------------------------
// Timer control fields.
// -----------------------------------------------------------------------------
`define TCV_TC_OVF_FLAG     0
`define TCV_TC_OVF_IE       1
`define TCV_TC_CLEAR        2
`define TCV_TC_MODE_LO      4
`define TCV_TC_MODE_HI      5

// -----------------------------------------------------------------------------
// Channel control fields.
// -----------------------------------------------------------------------------
`define TCV_CC_FLAG         0
`define TCV_CC_OUT          2
`define TCV_CC_IE           4
`define TCV_CC_MODE_LO      5
`define TCV_CC_MODE_HI      7
`define TCV_CC_CAP          8

// -----------------------------------------------------------------------------
// Vector numbers and reset values.
// -----------------------------------------------------------------------------
`define TCV_VEC_NONE        16'h0000
`define TCV_VEC_CH1         16'h0002
`define TCV_VEC_CH2         16'h0004
`define TCV_VEC_OVF         16'h000a
`define TCV_RST_WORD        16'h0000

`endif

// ===== tcv_pkg.sv
// Types of the capture/compare timer.
// Assumes nothing beyond a SystemVerilog compiler.
package tcv_pkg;

    // Counting modes held in the timer control register.
    typedef enum logic [1:0] {
        TCV_STOP = 2'h0,
        TCV_UP   = 2'h1,
        TCV_CONT = 2'h2,
        TCV_UPDN = 2'h3
    } tcv_count_mode_t;

    // Output modes of a channel's output unit.
    typedef enum logic [2:0] {
        TCV_OM_OUTBIT = 3'h0,
        TCV_OM_SET    = 3'h1,
        TCV_OM_TGLRST = 3'h2,
        TCV_OM_SETRST = 3'h3,
        TCV_OM_TOGGLE = 3'h4,
        TCV_OM_RESET  = 3'h5,
        TCV_OM_TGLSET = 3'h6,
        TCV_OM_RSTSET = 3'h7
    } tcv_out_mode_t;

endpackage

// ===== tcv_timer_sva.sv
// Port-level checker of the capture/compare timer.
// Assumes it is bound to tcv_timer and sees only its ports.
`timescale 1ns/1ps
module tcv_timer_sva (
    input wire logic        clk_i,               // Timer clock.
    input wire logic        resetn_i,            // Reset, active low.
    input wire logic [15:0] addr_i,              // Register offset.
    input wire logic        rd_i,                // Read strobe.
    input wire logic [15:0] rdata_o,             // Read data.
    input wire logic        global_irq_enable_i, // Core enable.
    input wire logic        ch0_irq_ack_i,       // Channel 0 service.
    input wire logic [2:0]  capture_i,           // Capture pulses.
    input wire logic        ch0_irq_o,           // Channel 0 request.
    input wire logic        shared_irq_o,        // Shared request.
    input wire logic [2:0]  channel_output_o     // Channel outputs.
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // A read of the vector register; it also clears a flag.
    logic vrd;
    assign vrd = rd_i && (addr_i == 16'h012e);

    ch0_gate_a: assert property (ch0_irq_o |-> global_irq_enable_i)
        else $error("channel 0 request without global enable");
    shared_gate_a: assert property (shared_irq_o |-> global_irq_enable_i)
        else $error("shared request without global enable");
    vec_code_a: assert property (vrd |=> rdata_o inside {16'h0000, 16'h0002, 16'h0004, 16'h000a})
        else $error("vector code outside the legal set");
    vec_zero_a: assert property (vrd && global_irq_enable_i && !shared_irq_o |=> rdata_o == 16'h0000)
        else $error("vector not zero while nothing is requested");
    vec_live_a: assert property (vrd && shared_irq_o |=> rdata_o != 16'h0000)
        else $error("vector zero while shared request stands");
    ack_clear_a: assert property (ch0_irq_ack_i && ch0_irq_o && !capture_i[0] |=> !ch0_irq_o)
        else $error("channel 0 request survived its service");
    read_hold_a: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_i && addr_i == 16'h0100 |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    wake_quiet_a: assert property ($rose(resetn_i) |-> !ch0_irq_o && !shared_irq_o && channel_output_o == 3'h0)
        else $error("outputs not quiet after reset");
endmodule // tcv_timer_sva

bind tcv_timer tcv_timer_sva u_sva (.clk_i, .resetn_i, .addr_i, .rd_i, .rdata_o,
    .global_irq_enable_i, .ch0_irq_ack_i, .capture_i, .ch0_irq_o, .shared_irq_o,
    .channel_output_o);

// ===== tcv_core_model.sv
// Processor core model: services the channel 0 request after a latency.
// Assumes the testbench enables service and drives the global enable.
`timescale 1ns/1ps
module tcv_core_model #(
    parameter int LAT = 2            // Cycles of interrupt latency.
)(
    input  wire logic clk_i,         // Timer clock.
    input  wire logic resetn_i,      // Reset, active low.
    input  wire logic serve_i,       // Core accepts channel 0 requests.
    input  wire logic ch0_irq_i,     // Channel 0 request.
    output logic      ack_o          // One-cycle service pulse.
);
    logic [3:0] wait_ff;             // Latency count.
    // The wait restarts after each pulse so one request is served once.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wait_ff <= 4'h0;
            ack_o   <= 1'b0;
        end
        else
        begin
            ack_o <= 1'b0;
            if (!(serve_i && ch0_irq_i) || ack_o)
                wait_ff <= 4'h0;
            else if (wait_ff == LAT[3:0])
                ack_o <= 1'b1;
            else
                wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule // tcv_core_model

// ===== timer_output_irq_vector_tb.sv
// Testbench of the timer: register tasks, vector, service and duty tests.
// Assumes tcv_timer, its package and the core model are compiled first.
`timescale 1ns/1ps
module timer_output_irq_vector_tb;
    import tcv_pkg::*;
    logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, global_irq_enable = 0, serve = 0, ack;
    logic [15:0] addr_i = 0, wdata_i = 0, rdata_o, d;
    logic [2:0]  capture_i = 0, outs;
    logic        ch0_irq_o, shared_irq_o;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    logic [15:0] ofs [10] = '{16'h012e, 16'h0160, 16'h0162, 16'h0164, 16'h0166,
                              16'h0170, 16'h0172, 16'h0174, 16'h0176, 16'h0100};
    logic [15:0] vseq [4] = '{16'h0002, 16'h0004, 16'h000a, 16'h0000};

    always #5 clk_i = ~clk_i;
    tcv_timer u_dut (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .global_irq_enable_i(global_irq_enable), .ch0_irq_ack_i(ack), .capture_i, .ch0_irq_o,
        .shared_irq_o, .channel_output_o(outs));
    tcv_core_model u_core (.clk_i, .resetn_i, .serve_i(serve), .ch0_irq_i(ch0_irq_o),
        .ack_o(ack));

    // -------------------------------------------------------------------------
    // Bus and compare tasks; strobes last one cycle, data sampled after it.
    // -------------------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("unexpected %s exp %h got %h", n, e, g);
            n_errors++;
        end
    endtask
    task automatic rchk(input string n, input logic [15:0] a, input logic [15:0] e);
        rd(a);
        chk(n, e, d);
    endtask
    // Counts low cycles of one output; a whole number of periods fixes the result.
    task automatic duty(input int n, input int ch, input logic [15:0] e);
        int lows;
        lows = 0;
        repeat (n) @(posedge clk_i) #1 lows += (outs[ch] === 1'b0);
        chk("low cycles", e, 16'(lows));
    endtask
    task automatic finish_test;
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // A hang counts as a mismatch.
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            finish_test();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        foreach (ofs[i]) rchk("reset value", ofs[i], 16'h0000);
        @(posedge clk_i) global_irq_enable <= 1'b1;
        wr(16'h0164, 16'h0001);
        rchk("sw flag", 16'h0164, 16'h0001);
        wr(16'h0164, 16'h0011);
        wr(16'h0166, 16'h0011);
        wr(16'h0160, 16'h0003);
        chk("shared", 1, shared_irq_o);
        foreach (vseq[i]) rchk("vector", 16'h012e, vseq[i]);
        chk("shared", 0, shared_irq_o);
        wr(16'h0164, 16'h0011);
        wr(16'h0166, 16'h0011);
        wr(16'h012e, 16'h0000);
        rchk("vector", 16'h012e, 16'h0004);
        wr(16'h0166, 16'h0001);
        wr(16'h0160, 16'h0003);
        rchk("vector", 16'h012e, 16'h000a);
        rchk("vector", 16'h012e, 16'h0000);
        rchk("ch2 ctrl", 16'h0166, 16'h0001);
        rchk("timer ctrl", 16'h0160, 16'h0002);
        @(posedge clk_i) global_irq_enable <= 1'b0;
        wr(16'h0164, 16'h0011);
        chk("shared", 0, shared_irq_o);
        @(posedge clk_i) global_irq_enable <= 1'b1;
        #1 chk("shared", 1, shared_irq_o);
        rchk("vector", 16'h012e, 16'h0002);
        @(posedge clk_i) serve <= 1'b1;
        wr(16'h0162, 16'h0011);
        chk("ch0 req", 1, ch0_irq_o);
        repeat (12) @(posedge clk_i);
        rchk("ch0 ctrl", 16'h0162, 16'h0010);
        wr(16'h0166, 16'h0004);
        chk("out2", 1, outs[2]);
        wr(16'h0172, 16'h0009);
        wr(16'h0174, 16'h0004);
        wr(16'h0164, 16'h00e0);
        wr(16'h0160, 16'h0014);
        repeat (30) @(posedge clk_i);
        duty(100, 1, 16'd60);
        rd(16'h0164);
        chk("ch1 flag", 1, d & 16'h0001);
        rd(16'h0160);
        chk("wrap flag", 1, d & 16'h0001);
        wr(16'h0160, 16'h0034);
        repeat (40) @(posedge clk_i);
        duty(180, 1, 16'd130);
        rd(16'h0160);
        chk("updn flag", 1, d & 16'h0001);
        wr(16'h0164, 16'h0060);
        wr(16'h0160, 16'h0020);
        wr(16'h0170, 16'h0006);
        repeat (4) @(posedge clk_i);
        #1 chk("cont reset", 0, outs[1]);
        wr(16'h0170, 16'h0000);
        repeat (6) @(posedge clk_i);
        #1 chk("cont set", 1, outs[1]);
        repeat (4) @(posedge clk_i);
        #1 chk("cont reset", 0, outs[1]);
        wr(16'h0166, 16'h0110);
        @(posedge clk_i) capture_i <= 3'h4;
        @(posedge clk_i) capture_i <= 3'h0;
        rchk("vector", 16'h012e, 16'h0004);
        wr(16'h0164, 16'h0000);
        finish_test();
    end
endmodule // timer_output_irq_vector_tb
